/* pat_arb.sv */
// Top of the port arbitration table: walks thirty-two slots, one grant per period.
// Assumes requests and period strobe come from core-clock logic.
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
module pat_arb
(
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [11:0]          wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    // Arbitration
    input  wire logic [2:0]           req_i,
    input  wire logic                 period_i,
    output logic                      grant_valid_o,
    output logic [1:0]                grant_port_o,
    output logic [4:0]                grant_slot_o
);
    typedef enum logic [0:0] {
        PAT_IDLE = 1'b0,
        PAT_RUN  = 1'b1
    } pat_state_t;

    pat_pkg::pat_wb_req_t wb_req;
    pat_pkg::pat_wb_rsp_t wb_rsp;
    pat_pkg::pat_grant_t  grant_r, grant_nxt;
    pat_state_t           state_r, state_nxt;
    logic [4:0]           slot_r, slot_nxt;
    logic [63:0]          table_w;
    logic                 enable;
    logic [1:0]           egress;
    logic [31:0]          usable;
    logic [31:0]          stat;
    logic                 found;
    logic [4:0]           pick;
    logic [4:0]           cand;

    assign wb_req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                      sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    pat_wb_regs u_regs
    (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .req_i    (wb_req),
        .rsp_o    (wb_rsp),
        .stat_i   (stat),
        .table_o  (table_w),
        .enable_o (enable),
        .egress_o (egress)
    );

    genvar g;
    generate
        for (g = 0; g < pat_pkg::PAT_SLOTS; g++)
        begin : g_slot
            pat_slot_dec u_dec
            (
                .code_i   (table_w[g*pat_pkg::PAT_SLOT_W +: pat_pkg::PAT_SLOT_W]),
                .egress_i (egress),
                .req_i    (req_i),
                .usable_o (usable[g])
            );
        end
    endgenerate

    // Search forward from the current slot in one cycle, so invalid slots cost no time.
    always_comb
    begin
        found = 1'b0;
        pick  = slot_r;
        cand  = 5'h00;
        for (int i = 0; i < pat_pkg::PAT_SLOTS; i++)
        begin
            cand = slot_r + 5'(i);
            if (!found && usable[cand])
            begin
                found = 1'b1;
                pick  = cand;
            end
        end
    end

    always_comb
    begin
        state_nxt = state_r;
        slot_nxt  = slot_r;
        grant_nxt = '{valid: 1'b0, port: grant_r.port, slot: grant_r.slot};
        case (state_r)
            PAT_IDLE:
            begin
                slot_nxt = 5'h00;
                if (enable)
                begin
                    state_nxt = PAT_RUN;
                end
            end
            PAT_RUN:
            begin
                if (!enable)
                begin
                    state_nxt = PAT_IDLE;
                end
                else if (period_i && found)
                begin
                    // Serve the slot matching this period, then move past it.
                    grant_nxt = '{valid: 1'b1,
                                  port:  table_w[pick*2 +: 2],
                                  slot:  pick};
                    slot_nxt  = pick + 5'h01;
                end
            end
            default:
            begin
                state_nxt = PAT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= PAT_IDLE;
            slot_r  <= 5'h00;
            grant_r <= '{valid: 1'b0, port: 2'h0, slot: 5'h00};
        end
        else
        begin
            state_r <= state_nxt;
            slot_r  <= slot_nxt;
            grant_r <= grant_nxt;
        end
    end

    // Status layout: next slot in 4:0, last granted port in 9:8, running flag in bit 12.
    assign stat = {19'h0, (state_r == PAT_RUN), 2'h0, grant_r.port, 3'h0, slot_r};
    assign wb_ack_o      = wb_rsp.ack;
    assign wb_dat_o      = wb_rsp.dat;
    assign grant_valid_o = grant_r.valid;
    assign grant_port_o  = grant_r.port;
    assign grant_slot_o  = grant_r.slot;
endmodule : pat_arb

/* pat_pkg.sv */
// Package for the port arbitration table block: register map, slot layout, port codes.
// Assumes a single 20 MHz core clock and a classic Wishbone register bus.
// Functional notes
// - Sixteen 2-bit slots per word; slot 16 in bits 1:0, slot 31 in 31:30.
// - Slot code 0 upstream port, 1 second port, 2 third port, 3 reserved.
// - A slot naming an invalid port is skipped with no arbitration time spent.
// - All slot fields are read/write and reset to zero, selecting upstream.
// - Each arbitration period serves the port named by the matching slot.
// - Slots 0 to 15 sit in the preceding word with identical layout.
package pat_pkg;

    localparam int          PAT_SLOTS       = 32;
    localparam int          PAT_SLOTS_WORD  = 16;
    localparam int          PAT_SLOT_W      = 2;
    localparam int          PAT_IDX_W       = 5;
    localparam int          PAT_ADR_W       = 12;

    // Byte addresses of the two table words, the control word and the status word.
    localparam logic [11:0] PAT_TBL0_ADDR   = 12'h120;
    localparam logic [11:0] PAT_TBL1_ADDR   = 12'h124;
    localparam logic [11:0] PAT_CTRL_ADDR   = 12'h128;
    localparam logic [11:0] PAT_STAT_ADDR   = 12'h12c;

    localparam logic [31:0] PAT_TBL_RESET   = 32'h0000_0000;

    // Control word fields.
    localparam int          PAT_CTRL_EN_BIT = 0;
    localparam int          PAT_CTRL_EG_LSB = 4;
    localparam logic [1:0]  PAT_EGRESS_RST  = 2'h1;

    // Status word fields.
    localparam int          PAT_STAT_IDX_LSB = 0;
    localparam int          PAT_STAT_PRT_LSB = 8;
    localparam int          PAT_STAT_ACT_BIT = 12;

    localparam logic [1:0]  PAT_PORT_UP     = 2'h0;
    localparam logic [1:0]  PAT_PORT_B      = 2'h1;
    localparam logic [1:0]  PAT_PORT_C      = 2'h2;
    localparam logic [1:0]  PAT_PORT_RSVD   = 2'h3;
    localparam int          PAT_PORTS       = 3;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } pat_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pat_wb_rsp_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        logic [4:0] slot;
    } pat_grant_t;

endpackage : pat_pkg

/* pat_slot_dec.sv */
// Decodes one 2-bit slot entry against the requests and the egress port.
// Assumes requests are synchronous to the core clock.
`timescale 1ns/1ns
module pat_slot_dec
(
    // Slot entry and context
    input  wire logic [1:0] code_i,
    input  wire logic [1:0] egress_i,
    input  wire logic [2:0] req_i,
    // Result
    output logic            usable_o
);
    always_comb
    begin
        // Reserved or egress codes are treated as invalid and skipped.
        usable_o = (code_i != pat_pkg::PAT_PORT_RSVD) && (code_i != egress_i)
                   && req_i[code_i];
    end
endmodule : pat_slot_dec

/* pat_wb_regs.sv */
// Wishbone classic slave holding the two table words and the control word.
// Assumes a single-cycle classic master; ack follows one cycle after stb.
`timescale 1ns/1ns
module pat_wb_regs
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    // Bus
    input  wire pat_pkg::pat_wb_req_t req_i,
    output pat_pkg::pat_wb_rsp_t     rsp_o,
    // Block state
    input  wire logic [31:0]         stat_i,
    output logic [63:0]              table_o,
    output logic                     enable_o,
    output logic [1:0]               egress_o
);
    logic [31:0] tbl0_r, tbl0_nxt, tbl1_r, tbl1_nxt, ctrl_r, ctrl_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] rdat_r, rdat_nxt;
    logic        hit;
    logic [31:0] wmask;

    always_comb
    begin
        tbl0_nxt = tbl0_r;
        tbl1_nxt = tbl1_r;
        ctrl_nxt = ctrl_r;
        rdat_nxt = 32'h0000_0000;
        wmask    = {{8{req_i.sel[3]}}, {8{req_i.sel[2]}}, {8{req_i.sel[1]}}, {8{req_i.sel[0]}}};
        // A new access is taken only when no ack is outstanding.
        hit      = req_i.cyc && req_i.stb && !ack_r;
        ack_nxt  = hit;
        if (hit && req_i.we)
        begin
            case (req_i.adr)
                pat_pkg::PAT_TBL0_ADDR: tbl0_nxt = (tbl0_r & ~wmask) | (req_i.dat & wmask);
                pat_pkg::PAT_TBL1_ADDR: tbl1_nxt = (tbl1_r & ~wmask) | (req_i.dat & wmask);
                pat_pkg::PAT_CTRL_ADDR: ctrl_nxt = ((ctrl_r & ~wmask) | (req_i.dat & wmask))
                                                   & 32'h0000_0031;
                default:                ctrl_nxt = ctrl_r;
            endcase
        end
        else if (hit)
        begin
            case (req_i.adr)
                pat_pkg::PAT_TBL0_ADDR: rdat_nxt = tbl0_r;
                pat_pkg::PAT_TBL1_ADDR: rdat_nxt = tbl1_r;
                pat_pkg::PAT_CTRL_ADDR: rdat_nxt = ctrl_r;
                pat_pkg::PAT_STAT_ADDR: rdat_nxt = stat_i;
                default:                rdat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            tbl0_r <= pat_pkg::PAT_TBL_RESET;
            tbl1_r <= pat_pkg::PAT_TBL_RESET;
            ctrl_r <= {26'h0, pat_pkg::PAT_EGRESS_RST, 4'h0};
            ack_r  <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end
        else
        begin
            tbl0_r <= tbl0_nxt;
            tbl1_r <= tbl1_nxt;
            ctrl_r <= ctrl_nxt;
            ack_r  <= ack_nxt;
            rdat_r <= rdat_nxt;
        end
    end

    assign rsp_o.ack = ack_r;
    assign rsp_o.dat = rdat_r;
    assign table_o   = {tbl1_r, tbl0_r};
    assign enable_o  = ctrl_r[pat_pkg::PAT_CTRL_EN_BIT];
    assign egress_o  = ctrl_r[pat_pkg::PAT_CTRL_EG_LSB +: 2];
endmodule : pat_wb_regs

/* pat_arb_assertions.sv */
// Port checks for the arbitration table top.
// Bound below to every instance of it.
`timescale 1ns/1ns
module pat_arb_assertions
(
    // Clock, reset, bus
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // Arbitration
    input wire logic [2:0] req_i,
    input wire logic       period_i,
    input wire logic       grant_valid_o,
    input wire logic [1:0] grant_port_o,
    input wire logic [4:0] grant_slot_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_bus_answer: assert property (s_take |=> wb_ack_o)
        else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
        else $error("stray ack");
    a_grant_cause: assert property (grant_valid_o |-> $past(period_i))
        else $error("stray grant");
    a_grant_code: assert property (grant_valid_o |-> grant_port_o != 2'h3)
        else $error("bad port");
    a_grant_req: assert property (grant_valid_o |-> $past(req_i) >> grant_port_o & 3'h1)
        else $error("idle port");
    a_port_hold: assert property (!grant_valid_o |-> $stable(grant_port_o))
        else $error("port moved");
    a_slot_hold: assert property (!grant_valid_o |-> $stable(grant_slot_o))
        else $error("slot moved");
endmodule : pat_arb_assertions
bind pat_arb pat_arb_assertions u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .req_i, .period_i, .grant_valid_o, .grant_port_o, .grant_slot_o);

/* pat_req_model.sv */
// Ingress request model: one request level per port.
// Assumes the bench sets the pattern with each period pulse.
`timescale 1ns/1ns
module pat_req_model
(
    // Reset and pattern
    input  wire logic       rst_i,
    input  wire logic [2:0] pat_i,
    // Requests, one bit a port
    output logic [2:0]      req_o
);
    always_comb
    begin
        req_o = rst_i ? 3'h0 : pat_i;
    end
endmodule : pat_req_model

/* pat_arb_tb_top.sv */
// Bench for the arbitration table top against a reference arbiter.
// Assumes the checker binds itself and the request model drives req_i.
`timescale 1ns/1ns
module pat_arb_tb_top;
    pat_pkg::pat_wb_req_t wb = '0;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        per = 1'b0;
    logic        ack, gv;
    logic [1:0]  gp, eg, lp = 2'h0;
    logic [2:0]  pat = 3'h0, req;
    logic [4:0]  gs;
    logic [31:0] rd, rdat;
    logic [63:0] tbl;
    int          mismatches = 0, n_checks = 0, ptr;
    always #25 clk_i = ~clk_i;
    pat_arb DUT (.clk_i, .rst_i, .wb_cyc_i(wb.cyc), .wb_stb_i(wb.stb), .wb_we_i(wb.we),
        .wb_sel_i(wb.sel), .wb_adr_i(wb.adr), .wb_dat_i(wb.dat), .wb_ack_o(ack),
        .wb_dat_o(rdat), .req_i(req), .period_i(per), .grant_valid_o(gv),
        .grant_port_o(gp), .grant_slot_o(gs));
    pat_req_model u_req (.rst_i, .pat_i(pat), .req_o(req));
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic bus(input logic w, logic [11:0] a, logic [31:0] v, logic [3:0] s);
        int i;
        @(posedge clk_i);
        wb <= '{1'b1, 1'b1, w, s, a, v};
        for (i = 0; i < 8 && ack !== 1'b1; i++)
            @(posedge clk_i);
        mismatches += (i == 8);
        if (i == 8)
            test_done();
        rd = rdat;
        wb <= '0;
        @(posedge clk_i);
    endtask : bus
    // The model leaves the pointer alone when no slot can be served.
    task automatic period(logic [2:0] r);
        int s = -1, i;
        for (i = 31; i >= 0; i--)
            if (r[tbl[2 * ((ptr + i) % 32) +: 2]])
                s = (ptr + i) % 32;
        @(posedge clk_i);
        pat <= r;
        per <= 1'b1;
        @(posedge clk_i);
        per <= 1'b0;
        for (i = 0; i < 3 && gv !== 1'b1; i++)
            @(posedge clk_i);
        chk({31'h0, gv}, {31'h0, s >= 0});
        if (s >= 0)
        begin
            chk({25'h0, gp, gs}, {25'h0, tbl[2 * s +: 2], 5'(s)});
            lp  = tbl[2 * s +: 2];
            ptr = (s + 1) % 32;
        end
    endtask : period
    initial
    begin
        void'($urandom(17));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int j = 0; j < 5; j++)
        begin
            bus(1'b0, 12'h120 + 12'(4 * j), 32'h0, 4'hf);
            chk(rd, (j == 2) ? 32'h10 : 32'h0);
        end
        bus(1'b1, 12'h124, 32'hc3a5_5a3c, 4'hf);
        bus(1'b1, 12'h124, 32'h3c5a_a5c3, 4'h2);
        bus(1'b0, 12'h124, 32'h0, 4'hf);
        chk(rd, 32'hc3a5_a53c);
        $display("register test done");
        for (int e = 0; e < 3; e += 2)
        begin
            eg = 2'(e);
            for (int j = 0; j < 32; j++)
                tbl[2 * j +: 2] = 2'($urandom % 2) + ((e == 0) ? 2'h1 : 2'h0);
            bus(1'b1, 12'h120, tbl[31:0], 4'hf);
            bus(1'b1, 12'h124, tbl[63:32], 4'hf);
            bus(1'b1, 12'h128, 32'h0, 4'hf);
            bus(1'b1, 12'h128, {26'h0, eg, 4'h1}, 4'hf);
            ptr = 0;
            repeat (40) period(3'($urandom));
        end
        bus(1'b0, 12'h12c, 32'h0, 4'hf);
        chk(rd, {19'h0, 1'b1, 2'h0, lp, 3'h0, 5'(ptr)});
        $display("arbitration test done");
        // A reset in mid-run must bring every table word and the control word back.
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int j = 0; j < 5; j++)
        begin
            bus(1'b0, 12'h120 + 12'(4 * j), 32'h0, 4'hf);
            chk(rd, (j == 2) ? 32'h10 : 32'h0);
        end
        $display("reset test done");
        test_done();
    end
endmodule : pat_arb_tb_top
